// [rtl/dfa_switch.sv]
/*
  Direction-finding antenna switch: AHB-Lite registers, switch/sample timing in 16 MHz
  ticks, antenna slot sequencing with wrap, pin driving and sample write-out.
  Assumes a single AHB-Lite master, crcEnd pulses from the radio, samples from the
  radio's IQ path and a memory port that accepts one word when memReady is high.
*/
`timescale 1ns/1ps
module dfa_switch
  import dfa_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic crcEnd,
  input wire logic sampleValid,
  input wire logic [31:0] sampleData,
  input wire logic memReady,
  output dfa_sample_s memWrite,
  output logic [31:0] pinOut,
  output logic [31:0] pinOe,
  output logic radioPowered
);

  typedef enum {SEQ_IDLE, SEQ_WAIT, SEQ_SLOTS} dfa_seq_e;

  // address phase capture
  dfa_req_s req_q;
  wire logic addrTaken = hsel && hready && (htrans == HTRANS_NONSEQ);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= '0;
    end else if (clockEnable) begin
      req_q <= addrTaken ? dfa_req_s'{sel: 1'b1, write: hwrite, addr: haddr[11:0]} : '0;
    end
  end
  wire logic wrEn = req_q.sel && req_q.write && clockEnable;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  wire logic isPinSel = (req_q.addr >= OFF_PIN_SELECT) && (req_q.addr <= OFF_PIN_SELECT_END);
  // select index counts from the first select word, not from address bits
  wire logic [11:0] pinOff = req_q.addr - OFF_PIN_SELECT;
  wire logic [2:0] pinIdx = pinOff[4:2];

  // registers
  logic [31:0] startOffsets_q;
  logic [31:0] pinSelect_q [PIN_COUNT];
  logic [31:0] bufPointer_q;
  logic [LIMIT_W-1:0] bufLimit_q;
  logic [31:0] xferCount_q;
  logic power_q;
  logic [CTRL_SLOTS_W-1:0] slotTotal_q;

  wire logic active = power_q && clockEnable;
  wire logic patPush = wrEn && power_q && hit(req_q.addr, OFF_PATTERN_FIFO);
  wire logic patClear = wrEn && power_q && hit(req_q.addr, OFF_PATTERN_CLEAR);
  wire logic startReq = wrEn && power_q && hit(req_q.addr, OFF_SEQ_CONTROL)
    && hwdata[CTRL_START_BIT];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      startOffsets_q <= RST_START_OFFSETS;
      bufPointer_q <= RST_BUF_POINTER;
      bufLimit_q <= RST_BUF_LIMIT;
      power_q <= RST_POWER;
      slotTotal_q <= '0;
    end else if (wrEn) begin
      if (hit(req_q.addr, OFF_START_OFFSETS)) startOffsets_q <= hwdata;
      if (hit(req_q.addr, OFF_BUF_POINTER)) bufPointer_q <= hwdata;
      if (hit(req_q.addr, OFF_BUF_LIMIT)) bufLimit_q <= hwdata[LIMIT_W-1:0];
      if (hit(req_q.addr, OFF_POWER)) power_q <= hwdata[0];
      if (hit(req_q.addr, OFF_SEQ_CONTROL)) begin
        slotTotal_q <= hwdata[CTRL_SLOTS_LSB +: CTRL_SLOTS_W];
      end
    end
  end

  for (genvar n = 0; n < PIN_COUNT; n++) begin : g_psel
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        pinSelect_q[n] <= RST_PIN_SELECT;
      end else if (wrEn && isPinSel && pinIdx == 3'(n)) begin
        pinSelect_q[n] <= hwdata;
      end
    end
  end

  // 16 MHz tick from 200 MHz clock
  logic [TICK_PHASE_W-1:0] phase_q;
  wire logic [TICK_PHASE_W:0] phaseSum = {1'b0, phase_q} + {1'b0, TICK_STEP};
  wire logic tickWrap = phaseSum >= {1'b0, TICK_WRAP};
  wire logic tick = active && tickWrap;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= '0;
    end else if (active) begin
      phase_q <= tickWrap ? TICK_PHASE_W'(phaseSum - {1'b0, TICK_WRAP})
                          : phaseSum[TICK_PHASE_W-1:0];
    end
  end

  wire logic signed [SWITCH_DELAY_W-1:0] switchStartDelay =
    startOffsets_q[SWITCH_DELAY_LSB +: SWITCH_DELAY_W];
  wire logic signed [SAMPLE_SHIFT_W-1:0] sampleStartShift =
    startOffsets_q[SAMPLE_SHIFT_LSB +: SAMPLE_SHIFT_W];
  // negative switch delay cannot precede the trigger here, so it clamps to zero
  wire logic [SWITCH_DELAY_W-1:0] switchWait =
    switchStartDelay[SWITCH_DELAY_W-1] ? '0 : switchStartDelay;
  wire logic signed [SWITCH_DELAY_W+1:0] sampleAtS =
    (SWITCH_DELAY_W+2)'(SLOT_TICKS) + (SWITCH_DELAY_W+2)'(sampleStartShift);
  wire logic [SWITCH_DELAY_W-1:0] sampleAt =
    sampleAtS[SWITCH_DELAY_W+1] ? '0 : SWITCH_DELAY_W'(sampleAtS);

  // antenna slot sequencer
  dfa_seq_e state_q;
  dfa_seq_e state_d;
  logic [SWITCH_DELAY_W-1:0] ticks_q;
  logic [PATTERN_IDX_W-1:0] slotIdx_q;
  logic [CTRL_SLOTS_W-1:0] slotsDone_q;
  logic sampling_q;
  logic [PATTERN_IDX_W-1:0] patCount;
  logic [PATTERN_W-1:0] patData;
  wire logic slotEnd = tick && (ticks_q == SWITCH_DELAY_W'(SLOT_TICKS - 1));
  wire logic waitEnd = tick && (ticks_q >= switchWait);
  wire logic lastSlot = (slotsDone_q + 1'b1) >= slotTotal_q;
  wire logic [PATTERN_IDX_W-1:0] nextIdx =
    (slotIdx_q + 1'b1 >= patCount) ? PATTERN_IDX_W'(1) : slotIdx_q + 1'b1;

  always_comb begin
    state_d = state_q;
    case (state_q)
      SEQ_IDLE: begin
        if (crcEnd || startReq) state_d = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (waitEnd) state_d = SEQ_SLOTS;
      end
      SEQ_SLOTS: begin
        if (slotEnd && lastSlot) state_d = SEQ_IDLE;
      end
      default: state_d = SEQ_IDLE;
    endcase
    if (patClear || !power_q) state_d = SEQ_IDLE;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SEQ_IDLE;
      ticks_q <= '0;
      slotIdx_q <= '0;
      slotsDone_q <= '0;
    end else if (clockEnable) begin
      state_q <= state_d;
      if (state_q != state_d) begin
        ticks_q <= '0;
        slotIdx_q <= '0;
        slotsDone_q <= '0;
      end else if (state_q == SEQ_SLOTS && slotEnd) begin
        ticks_q <= '0;
        slotIdx_q <= nextIdx;
        slotsDone_q <= slotsDone_q + 1'b1;
      end else if (tick) begin
        ticks_q <= ticks_q + 1'b1;
      end
    end
  end

  // sampling window opens at the shifted point after switching starts
  // ticks since switching began; the sampling point may lie past the first slot
  logic [SWITCH_DELAY_W-1:0] elapsed_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      elapsed_q <= '0;
    end else if (clockEnable) begin
      if (state_q != state_d) begin
        elapsed_q <= '0;
      end else if (state_q == SEQ_SLOTS && tick) begin
        elapsed_q <= elapsed_q + 1'b1;
      end
    end
  end
  wire logic sampleOpen = (state_q == SEQ_SLOTS) && tick && (elapsed_q == sampleAt);
  logic [31:0] wordsDone_q;
  wire logic limitHit = wordsDone_q >= {{(32-LIMIT_W){1'b0}}, bufLimit_q};
  wire logic seqEnds = (state_q == SEQ_SLOTS) && (state_d != SEQ_SLOTS);
  wire logic storeSample = sampling_q && sampleValid && !limitHit && !memWrite.valid;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sampling_q <= 1'b0;
      wordsDone_q <= '0;
      xferCount_q <= RST_XFER_COUNT;
      memWrite <= '0;
    end else if (clockEnable) begin
      if (state_q == SEQ_IDLE && state_d == SEQ_WAIT) begin
        wordsDone_q <= '0;
      end else if (storeSample) begin
        wordsDone_q <= wordsDone_q + 1'b1;
      end
      if (sampleOpen) sampling_q <= 1'b1;
      else if (seqEnds) sampling_q <= 1'b0;
      if (storeSample) begin
        memWrite <= '{valid: 1'b1, addr: bufPointer_q + {wordsDone_q[29:0], 2'b00},
          data: sampleData};
      end else if (memReady) begin
        memWrite.valid <= 1'b0;
      end
      if (seqEnds) xferCount_q <= wordsDone_q;
    end
  end

  dfa_pattern_store u_store (
    .clock(clock),
    .reset_n(reset_n),
    .enable(clockEnable),
    .push(patPush),
    .pushData(hwdata[PATTERN_W-1:0]),
    .clear(patClear),
    .readIdx(slotIdx_q),
    .readData(patData),
    .count(patCount)
  );

  logic [PIN_COUNT*32-1:0] selFlat;
  for (genvar n = 0; n < PIN_COUNT; n++) begin : g_flat
    assign selFlat[n*32 +: 32] = pinSelect_q[n];
  end

  dfa_pin_mux u_mux (
    .pattern(patData),
    .selects(selFlat),
    .active(power_q && state_q == SEQ_SLOTS),
    .pinOut(pinOut),
    .pinOe(pinOe)
  );

  // read data: data phase, combinational on captured address
  logic [31:0] rdMux;
  always_comb begin
    rdMux = '0;
    if (hit(req_q.addr, OFF_START_OFFSETS)) rdMux = startOffsets_q;
    if (hit(req_q.addr, OFF_PATTERN_FIFO)) rdMux = 32'(patCount);
    if (isPinSel) rdMux = pinSelect_q[pinIdx];
    if (hit(req_q.addr, OFF_BUF_POINTER)) rdMux = bufPointer_q;
    if (hit(req_q.addr, OFF_BUF_LIMIT)) rdMux = 32'(bufLimit_q);
    if (hit(req_q.addr, OFF_XFER_COUNT)) rdMux = xferCount_q;
    if (hit(req_q.addr, OFF_SEQ_CONTROL)) rdMux = 32'(slotTotal_q) << CTRL_SLOTS_LSB;
    if (hit(req_q.addr, OFF_SEQ_STATUS)) rdMux = {24'h000000, 1'b0, sampling_q,
      patCount};
    if (hit(req_q.addr, OFF_POWER)) rdMux = 32'(power_q);
  end

  assign hrdata = (req_q.sel && !req_q.write) ? rdMux : '0;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign radioPowered = power_q;

endmodule // dfa_switch

// [rtl/dfa_pkg.sv]
/*
  Package for the direction-finding antenna switch: register offsets, field positions,
  reset values, timing constants and shared types.
  Assumes a 32-bit AHB-Lite register bus and a 200 MHz block clock.
*/
package dfa_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_START_OFFSETS = 12'h914;
  localparam logic [11:0] OFF_PATTERN_FIFO = 12'h928;
  localparam logic [11:0] OFF_PATTERN_CLEAR = 12'h92C;
  localparam logic [11:0] OFF_PIN_SELECT = 12'h930;
  localparam logic [11:0] OFF_PIN_SELECT_END = 12'h94C;
  localparam logic [11:0] OFF_BUF_POINTER = 12'h950;
  localparam logic [11:0] OFF_BUF_LIMIT = 12'h954;
  localparam logic [11:0] OFF_XFER_COUNT = 12'h958;
  localparam logic [11:0] OFF_SEQ_CONTROL = 12'h960;
  localparam logic [11:0] OFF_SEQ_STATUS = 12'h964;
  localparam logic [11:0] OFF_POWER = 12'hFFC;

  // field positions and widths
  localparam int SWITCH_DELAY_LSB = 0;
  localparam int SWITCH_DELAY_W = 13;
  localparam int SAMPLE_SHIFT_LSB = 16;
  localparam int SAMPLE_SHIFT_W = 12;
  localparam int PATTERN_W = 8;
  localparam int PIN_COUNT = 8;
  localparam int PIN_SEL_W = 5;
  localparam int PIN_CONNECT_BIT = 31;
  localparam int PATTERN_DEPTH = 40;
  localparam int PATTERN_IDX_W = 6;
  localparam int LIMIT_W = 16;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SLOTS_LSB = 8;
  localparam int CTRL_SLOTS_W = 8;

  // reset values
  localparam logic [31:0] RST_START_OFFSETS = 32'h0000_0000;
  localparam logic [LIMIT_W-1:0] RST_BUF_LIMIT = 16'h1000;
  localparam logic [31:0] RST_XFER_COUNT = 32'h0000_0000;
  localparam logic [31:0] RST_PIN_SELECT = 32'h8000_0000;
  localparam logic [31:0] RST_BUF_POINTER = 32'h0000_0000;
  localparam logic RST_POWER = 1'b1;

  // timing: fast-clock tick of 16 MHz derived from the 200 MHz block clock
  localparam int CLOCK_KHZ = 200000;
  localparam int FAST_TICK_KHZ = 16000;
  localparam int TICK_PHASE_W = 9;
  // a tick is 12.5 block cycles; accumulate in half units, wrap needs nine bits
  localparam logic [TICK_PHASE_W-1:0] TICK_STEP = TICK_PHASE_W'(2 * FAST_TICK_KHZ / 1000);
  localparam logic [TICK_PHASE_W-1:0] TICK_WRAP = TICK_PHASE_W'(2 * CLOCK_KHZ / 1000);
  localparam int SLOT_TICKS = 32;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HRESP_OKAY = 2'b00;

  typedef struct packed {
    logic sel;
    logic write;
    logic [11:0] addr;
  } dfa_req_s;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } dfa_sample_s;

endpackage

// [rtl/dfa_pattern_store.sv]
/*
  Antenna pattern array: appends one pattern per push until it holds forty, empties on clear,
  reads entries by slot index.
  Assumes the owner gates pushes while power is off.
*/
`timescale 1ns/1ps
module dfa_pattern_store
  import dfa_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic push,
  input wire logic [PATTERN_W-1:0] pushData,
  input wire logic clear,
  input wire logic [PATTERN_IDX_W-1:0] readIdx,
  output logic [PATTERN_W-1:0] readData,
  output logic [PATTERN_IDX_W-1:0] count
);

  logic [PATTERN_W-1:0] entries [PATTERN_DEPTH];
  logic [PATTERN_IDX_W-1:0] count_q;
  logic [PATTERN_IDX_W-1:0] count_d;
  wire logic isFull = (count_q == PATTERN_IDX_W'(PATTERN_DEPTH));
  wire logic doPush = push && !isFull;

  assign count_d = clear ? '0 : (doPush ? count_q + 1'b1 : count_q);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (enable) begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge clock) begin
    if (enable && doPush && !clear) begin
      entries[count_q] <= pushData;
    end
  end

  assign readData = (readIdx < count_q) ? entries[readIdx] : '0;
  assign count = count_q;

endmodule // dfa_pattern_store

// [rtl/dfa_pin_mux.sv]
/*
  Routes each pattern bit to the pin chosen by its select entry.
  Assumes selects are stable while the radio is enabled.
*/
`timescale 1ns/1ps
module dfa_pin_mux
  import dfa_pkg::*;
(
  input wire logic [PATTERN_W-1:0] pattern,
  input wire logic [PIN_COUNT*32-1:0] selects,
  input wire logic active,
  output logic [31:0] pinOut,
  output logic [31:0] pinOe
);

  logic [31:0] bitOut [PIN_COUNT+1];
  logic [31:0] bitOe [PIN_COUNT+1];
  assign bitOut[0] = '0;
  assign bitOe[0] = '0;

  for (genvar n = 0; n < PIN_COUNT; n++) begin : g_bit
    wire logic [31:0] sel = selects[n*32 +: 32];
    wire logic connected = !sel[PIN_CONNECT_BIT] && active;
    wire logic [31:0] onehot = 32'h0000_0001 << sel[PIN_SEL_W-1:0];
    assign bitOe[n+1] = bitOe[n] | (connected ? onehot : '0);
    assign bitOut[n+1] = bitOut[n] | ((connected && pattern[n]) ? onehot : '0);
  end

  assign pinOut = bitOut[PIN_COUNT];
  assign pinOe = bitOe[PIN_COUNT];

endmodule // dfa_pin_mux

// [sim/dfa_switch_sva.sv]
/*
  Checker for dfa_switch: bus answer, power bit, pattern count, sample handshake, pins.
  Assumes it is bound into every dfa_switch instance.
*/
`timescale 1ns/1ps
module dfa_switch_sva
  import dfa_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  input wire logic memReady,
  input wire dfa_sample_s memWrite,
  input wire logic [31:0] pinOe,
  input wire logic radioPowered
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic rdAny_q;
  logic rdCount_q;
  logic wrPower_q;
  wire take = hsel && hready && htrans == HTRANS_NONSEQ && clockEnable;
  wire atCount = haddr[11:0] == OFF_PATTERN_FIFO;
  wire atPower = haddr[11:0] == OFF_POWER;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdAny_q <= 1'b0;
      rdCount_q <= 1'b0;
      wrPower_q <= 1'b0;
    end else if (clockEnable) begin
      rdAny_q <= take && !hwrite;
      rdCount_q <= take && !hwrite && atCount;
      wrPower_q <= take && hwrite && atPower;
    end
  end
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("hresp not okay");
  a_read_idle: assert property (!rdAny_q |-> hrdata == 32'h0)
    else $error("hrdata set outside read");
  a_count_range: assert property (rdCount_q |-> hrdata <= 32'h28)
    else $error("pattern count above forty");
  a_power_reset: assert property ($rose(reset_n) |-> radioPowered)
    else $error("power off after reset");
  a_power_write: assert property (wrPower_q && clockEnable |=>
    radioPowered == $past(hwdata[0])) else $error("power bit not written");
  a_mem_hold: assert property (memWrite.valid && !memReady |=> memWrite.valid &&
    $stable(memWrite.addr) && $stable(memWrite.data)) else $error("write dropped");
  a_pin_count: assert property ($countones(pinOe) <= 8)
    else $error("too many pins driven");
  c_mem_write: cover property (memWrite.valid && memReady);
  c_pins_on: cover property (pinOe != 32'h0);
  c_count_read: cover property (rdCount_q);
endmodule // dfa_switch_sva
bind dfa_switch dfa_switch_sva i_dfa_switch_sva (.clock, .reset_n, .clockEnable, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .memReady,
  .memWrite, .pinOe, .radioPowered);

// [sim/dfa_antenna_model.sv]
/*
  External antenna switch: senses the levels on the pins the block drives.
  Assumes undriven pins float; they show the inverse of their last driven level.
*/
`timescale 1ns/1ps
module dfa_antenna_model (
  input wire logic clock,
  input wire logic [31:0] pinOut,
  input wire logic [31:0] pinOe,
  output logic [31:0] antenna
);
  logic [31:0] lastLevel_q = 32'h0;
  assign antenna = (pinOut & pinOe) | (~lastLevel_q & ~pinOe);
  always @(posedge clock) begin
    lastLevel_q <= (pinOut & pinOe) | (lastLevel_q & ~pinOe);
  end
endmodule // dfa_antenna_model

// [sim/test_direction_finding_antenna_switch.sv]
/*
  Testbench for dfa_switch: register table, pattern array, pin routing, slot wrap, sample
  write-out, clock enable and reset. Assumes zero-wait AHB-Lite answers.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module test_direction_finding_antenna_switch
  import dfa_pkg::*;
;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d;} dfa_row_s;
  logic clock, reset_n, clockEnable, hsel, hwrite, hready, crcEnd, sampleValid;
  logic [31:0] haddr, hwdata, hrdata, pinOut, pinOe, antenna, r, rdCap;
  logic [31:0] sampleData = 32'hD0D0_0000;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic hreadyout, radioPowered, rdyCap;
  logic memReady = 1'b0;
  dfa_sample_s memWrite;
  int n_fail = 0, checks_done = 0, nWr = 0, n;
  logic [31:0] expPins [5] = '{32'h1, 32'h20, 32'h200, 32'h20, 32'h200};
  dfa_row_s rows [$] = '{'{1'b0, 12'h914, 32'h0}, '{1'b0, 12'h928, 32'h0},
    '{1'b0, 12'h954, 32'h1000}, '{1'b0, 12'h958, 32'h0}, '{1'b0, 12'h930, 32'h80000000},
    '{1'b0, 12'h950, 32'h0}, '{1'b0, 12'hFFC, 32'h1}, '{1'b1, 12'h900, 32'hFFFFFFFF},
    '{1'b0, 12'h900, 32'h0}, '{1'b1, 12'h914, 32'h0FFF1FFF}, '{1'b0, 12'h914, 32'h0FFF1FFF},
    '{1'b1, 12'h958, 32'h5}, '{1'b0, 12'h958, 32'h0}, '{1'b1, 12'h928, 32'h1},
    '{1'b1, 12'h928, 32'h2}, '{1'b1, 12'h928, 32'h4}, '{1'b0, 12'h928, 32'h3},
    '{1'b1, 12'h92C, 32'h0}, '{1'b0, 12'h928, 32'h0}, '{1'b1, 12'hFFC, 32'h0},
    '{1'b1, 12'h928, 32'h1}, '{1'b0, 12'h928, 32'h0}, '{1'b1, 12'hFFC, 32'h1},
    '{1'b1, 12'h928, 32'h1}, '{1'b1, 12'h928, 32'h2}, '{1'b1, 12'h928, 32'h4},
    '{1'b1, 12'h914, 32'h0}, '{1'b1, 12'h930, 32'h0}, '{1'b1, 12'h934, 32'h5},
    '{1'b1, 12'h938, 32'h9}, '{1'b0, 12'h938, 32'h9}, '{1'b1, 12'h950, 32'h100},
    '{1'b1, 12'h954, 32'h2}, '{1'b1, 12'h960, 32'h500}};
  dfa_switch i_dfa_switch (.clock, .reset_n, .clockEnable, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .crcEnd, .sampleValid,
    .sampleData, .memReady, .memWrite, .pinOut, .pinOe, .radioPowered);
  dfa_antenna_model i_dfa_antenna_model (.clock, .pinOut, .pinOe, .antenna);
  // single slave: its ready is the bus ready
  assign hready = hreadyout;
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // answer captured with the edge's pre-update values
  always @(posedge clock) begin
    rdCap <= hrdata;
    rdyCap <= hreadyout;
    memReady <= ~memReady;
    if (memWrite.valid === 1'b1 && memReady === 1'b1) begin
      `CHK(memWrite.addr, 32'h100 + 32'(4 * nWr))
      `CHK(memWrite.data, 32'hD0D0_0000 + 32'(nWr))
      nWr++;
    end
    // sample word tells how many words were accepted before it
    sampleData <= 32'hD0D0_0000 + 32'(nWr);
  end
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {20'h0, a};
    do tick(); while (rdyCap !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do tick(); while (rdyCap !== 1'b1);
    q = rdCap;
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    give_verdict();
  end
  initial begin
    {reset_n, hsel, hwrite, crcEnd, sampleValid, htrans, haddr, hwdata} = '0;
    {clockEnable, hsize} = {1'b1, 3'h2};
    repeat (3) @(posedge clock);
    #1 reset_n <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d, r);
      if (!rows[i].w) `CHK(r, rows[i].d)
    end
    clockEnable <= 1'b0;
    bus(1'b1, 12'h914, 32'h55, r);
    clockEnable <= 1'b1;
    bus(1'b0, 12'h914, 32'h0, r);
    `CHK(r, 32'h0)
    sampleValid <= 1'b1;
    crcEnd <= 1'b1;
    tick();
    crcEnd <= 1'b0;
    n = 0;
    while (pinOe === 32'h0 && n < 2000) begin
      tick();
      n++;
    end
    `CHK(n < 2000, 1'b1)
    repeat (200) tick();
    for (int k = 0; k < 5; k++) begin
      `CHK(antenna & 32'h221, expPins[k])
      repeat (400) tick();
    end
    `CHK(pinOe, 32'h0)
    sampleValid <= 1'b0;
    `CHK(nWr, 2)
    bus(1'b0, 12'h958, 32'h0, r);
    `CHK(r, 32'h2)
    bus(1'b1, 12'h92C, 32'h0, r);
    repeat (41) bus(1'b1, 12'h928, 32'h3, r);
    bus(1'b0, 12'h928, 32'h0, r);
    `CHK(r, 32'h28)
    // start by control write, one slot
    bus(1'b1, 12'h960, 32'h101, r);
    n = 0;
    while (pinOe === 32'h0 && n < 100) begin
      tick();
      n++;
    end
    `CHK(n < 100, 1'b1)
    `CHK(pinOe, 32'h221)
    `CHK(antenna & 32'h221, 32'h21)
    bus(1'b0, 12'h964, 32'h0, r);
    `CHK(r, 32'h28)
    repeat (450) tick();
    `CHK(pinOe, 32'h0)
    bus(1'b0, 12'h958, 32'h0, r);
    `CHK(r, 32'h0)
    reset_n <= 1'b0;
    tick();
    tick();
    reset_n <= 1'b1;
    bus(1'b0, 12'h954, 32'h0, r);
    `CHK(r, 32'h1000)
    bus(1'b0, 12'h928, 32'h0, r);
    `CHK(r, 32'h0)
    give_verdict();
  end
endmodule // test_direction_finding_antenna_switch
